// ==== pcmx_regs.vh ====
// Register offsets, field positions, reset values and timing counts for the port C pin block
`ifndef PCMX_REGS_VH
`define PCMX_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PCMX_OFF_DATA     12'h000
`define PCMX_OFF_LATCH    12'h004
`define PCMX_OFF_DIR      12'h008
`define PCMX_OFF_CTRL     12'h00c
`define PCMX_OFF_STATUS   12'h010
`define PCMX_OFF_BUS      12'h014

// ****************************************
// Control register fields
// ****************************************
`define PCMX_CTRL_OPEN_DRAIN  0
`define PCMX_CTRL_HANDSHAKE   1
`define PCMX_CTRL_HS_DIR      2
`define PCMX_CTRL_EDGE        3
`define PCMX_CTRL_IRV         4
`define PCMX_CTRL_WIDTH       5

// ****************************************
// Status register fields
// ****************************************
`define PCMX_STAT_FLAG    0
`define PCMX_STAT_ARMED   1
`define PCMX_STAT_OSTRB   2

// ****************************************
// Reset values
// ****************************************
`define PCMX_RST_DIR      8'h00
`define PCMX_RST_DATA     8'h00
`define PCMX_RST_CTRL     5'h00

// ****************************************
// Timing: E cycle is four pclk cycles
// ****************************************
`define PCMX_E_CYCLE_NS   100
`define PCMX_CLK_NS       25
`define PCMX_E_CYCLES     (`PCMX_E_CYCLE_NS / `PCMX_CLK_NS)

`endif

// ==== pcmx_sync.v ====
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module pcmx_sync #(
	parameter WIDTH = 9
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             clk_en,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1;

	// ****************************************
	// Synchroniser
	// ****************************************
	// First stage feeds only the second stage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // pcmx_sync

// ==== pcmx_port.v ====
// Port C pin logic: multiplexed address/data bus and single-chip handshake port
`timescale 1ns/10ps
`include "pcmx_regs.vh"

// Contract
// - Expanded mode drives low address first half, then data out or in.
// - Tristate control 0 enables output buffers; 1 leaves pins as inputs.
// - Address path select drives address; write data path select drives data.
// - Read data latched during E high, passed only under read path select.
// - Writes look the same; internal reads drive out only with visibility.
// - A configuration bit selects internal read visibility on the port.
// - Low-power indicator low disables the port input buffers.
// - Direction register writable, readable, reset to zero, gates each buffer.
// - Open-drain bit kills high drive on all pins, single-chip only.
// - Output handshake drives direction-zero bits only while strobe is active.
// - Direction-one bits are driven outputs, except a high level under open drain.
// - Data read returns output latch if handshake output or direction out.
// - Writes to data or latched register load the same output latch.
// - Selected strobe edge captures pin data into the latched register.
// - Strobe edge in low power gives no valid latched data.
// - Interlocked handshake answers input strobe within one E cycle.
// - Handshake bits select simple strobe, full input or full output.
// - Register writes take effect mid E-high; the code applies them on the APB write clock edge instead.
// - Synchronised strobe sets flag and clears its auto-clear arming.
module pcmx_port #(
	parameter WIDTH = 8
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             clk_en,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [11:0]      paddr,
	input  wire [31:0]      pwdata,
	output reg  [31:0]      prdata,
	output wire             pready,
	output wire             pslverr,
	input  wire             expanded_mode,
	input  wire             lowpower_n,
	input  wire             e_clk,
	input  wire             port_tristate_ctl,
	input  wire             addr_path_sel,
	input  wire             wdata_path_sel,
	input  wire             rdata_path_sel,
	input  wire             internal_read,
	input  wire [WIDTH-1:0] bus_addr,
	input  wire [WIDTH-1:0] bus_wdata,
	input  wire [WIDTH-1:0] internal_rdata,
	output reg  [WIDTH-1:0] bus_rdata,
	input  wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_out,
	output wire [WIDTH-1:0] pin_oe,
	input  wire             input_strobe,
	output reg              output_strobe,
	output wire             strobe_a_flag,
	output wire             internal_read_visible
);
	// ****************************************
	// Declarations
	// ****************************************
	reg  [WIDTH-1:0] port_data_reg;
	reg  [WIDTH-1:0] latched_port_reg;
	reg  [WIDTH-1:0] port_direction;
	reg  [4:0]       ctrl;
	reg              flag;
	reg              armed;
	reg              strobe_prev;
	reg              e_prev;
	reg  [WIDTH-1:0] rd_hold;
	wire [WIDTH:0]   synced;
	wire [WIDTH-1:0] pin_buf;
	wire             strobe_s;
	wire             open_drain_sel;
	wire             handshake_sel;
	wire             hs_direction_sel;
	wire             strobe_edge_sel;
	wire             output_hs;
	wire             strobe_active;
	wire             strobe_capture_pulse;
	wire             wr;
	wire             rd;
	wire             data_write_strobe;
	wire             latch_write_strobe;
	wire             direction_write_strobe;
	wire             direction_read_strobe;
	wire             latched_read_strobe;
	wire             e_fall;
	wire             drive_bus;
	wire [WIDTH-1:0] bus_value;
	wire [WIDTH-1:0] sc_oe;
	wire [WIDTH-1:0] out_level;
	wire [WIDTH-1:0] data_read;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	pcmx_sync #(
		.WIDTH (WIDTH + 1)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.clk_en   (clk_en),
		.async_in ({input_strobe, pin_in}),
		.sync_out (synced)
	);

	// Input buffers gated off in low power
	assign pin_buf  = lowpower_n ? synced[WIDTH-1:0] : {WIDTH{1'b0}};
	assign strobe_s = synced[WIDTH];

	// ****************************************
	// Control decode
	// ****************************************
	assign open_drain_sel        = ctrl[`PCMX_CTRL_OPEN_DRAIN];
	assign handshake_sel         = ctrl[`PCMX_CTRL_HANDSHAKE];
	assign hs_direction_sel      = ctrl[`PCMX_CTRL_HS_DIR];
	assign strobe_edge_sel       = ctrl[`PCMX_CTRL_EDGE];
	assign internal_read_visible = ctrl[`PCMX_CTRL_IRV];
	// Both bits set means full-output handshake
	assign output_hs             = handshake_sel & hs_direction_sel;
	assign strobe_active         = ~(strobe_s ^ strobe_edge_sel);
	assign strobe_a_flag         = flag;

	// Edge select picks rising (1) or falling (0); ignored while asleep
	assign strobe_capture_pulse  = lowpower_n & (strobe_s != strobe_prev) &
		(strobe_s == strobe_edge_sel);

	// ****************************************
	// APB decode
	// ****************************************
	// Zero wait states; every access completes in its access phase
	assign pready                 = 1'b1;
	assign pslverr                = 1'b0;
	assign wr                     = psel & penable & pwrite & clk_en;
	assign rd                     = psel & penable & ~pwrite & clk_en;
	assign data_write_strobe      = wr & (paddr == `PCMX_OFF_DATA);
	assign latch_write_strobe     = wr & (paddr == `PCMX_OFF_LATCH);
	assign direction_write_strobe = wr & (paddr == `PCMX_OFF_DIR);
	assign direction_read_strobe  = rd & (paddr == `PCMX_OFF_DIR);
	assign latched_read_strobe    = rd & (paddr == `PCMX_OFF_LATCH);

	// ****************************************
	// Port registers
	// ****************************************
	// Bus write edge stands in for mid E-high timing of the write strobes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_data_reg  <= `PCMX_RST_DATA;
			port_direction <= `PCMX_RST_DIR;
			ctrl           <= `PCMX_RST_CTRL;
		end else if (clk_en) begin
			if (data_write_strobe || latch_write_strobe)
				port_data_reg <= pwdata[WIDTH-1:0];
			if (direction_write_strobe)
				port_direction <= pwdata[WIDTH-1:0];
			if (wr && paddr == `PCMX_OFF_CTRL)
				ctrl <= pwdata[`PCMX_CTRL_WIDTH-1:0];
		end
	end

	// ****************************************
	// Strobe capture and flag
	// ****************************************
	// Set beats a simultaneous clear so no strobe edge is lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_port_reg <= `PCMX_RST_DATA;
			strobe_prev      <= 1'b0;
			flag             <= 1'b0;
			armed            <= 1'b0;
		end else if (clk_en) begin
			strobe_prev <= strobe_s;
			if (strobe_capture_pulse) begin
				latched_port_reg <= pin_buf;
				flag             <= 1'b1;
				armed            <= 1'b0;
			end else begin
				if (rd && paddr == `PCMX_OFF_STATUS && flag)
					armed <= 1'b1;
				if (armed && (latched_read_strobe || latch_write_strobe)) begin
					flag  <= 1'b0;
					armed <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Output strobe (interlocked)
	// ****************************************
	// Full handshake: asserted on latch read/write, ended by next selected strobe edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_strobe <= 1'b0;
		end else if (clk_en) begin
			if (strobe_capture_pulse)
				output_strobe <= 1'b0;
			else if (handshake_sel && !hs_direction_sel && latched_read_strobe)
				output_strobe <= 1'b1;
			else if (output_hs && latch_write_strobe)
				output_strobe <= 1'b1;
			else if (!handshake_sel && data_write_strobe)
				output_strobe <= 1'b1;
		end
	end

	// ****************************************
	// Expanded bus read path
	// ****************************************
	assign e_fall = e_prev & ~e_clk;

	// Hold latch follows pins during E high, frozen after E falls
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			e_prev    <= 1'b0;
			rd_hold   <= {WIDTH{1'b0}};
			bus_rdata <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			e_prev <= e_clk;
			if (e_clk)
				rd_hold <= pin_buf;
			if (rdata_path_sel && e_fall)
				bus_rdata <= rd_hold;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	// Address phase and writes drive unless tristate control is 1; internal read data only with visibility
	assign drive_bus = ~port_tristate_ctl &
		(addr_path_sel | ~internal_read | internal_read_visible);
	assign bus_value = addr_path_sel ? bus_addr :
		(wdata_path_sel ? bus_wdata : internal_rdata);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
			// Handshake override only on direction-zero bits
			assign sc_oe[i] = port_direction[i] |
				(output_hs & strobe_active);
			assign out_level[i] = port_data_reg[i];
			// Open drain drops the high side: only a low is driven
			assign pin_oe[i] = expanded_mode ? drive_bus :
				(sc_oe[i] & ~(open_drain_sel & out_level[i]));
			assign pin_out[i] = expanded_mode ? bus_value[i] : out_level[i];
			assign data_read[i] = (output_hs | port_direction[i]) ?
				out_level[i] : pin_buf[i];
		end
	endgenerate

	// ****************************************
	// APB read mux
	// ****************************************
	always @* begin
		prdata = 32'h00000000;
		if (psel && !pwrite) begin
			case (paddr)
				`PCMX_OFF_DATA:   prdata[WIDTH-1:0] = data_read;
				`PCMX_OFF_LATCH:  prdata[WIDTH-1:0] = latched_port_reg;
				`PCMX_OFF_DIR:    prdata[WIDTH-1:0] = port_direction;
				`PCMX_OFF_CTRL:   prdata[`PCMX_CTRL_WIDTH-1:0] = ctrl;
				`PCMX_OFF_STATUS: prdata[2:0] = {output_strobe, armed, flag};
				`PCMX_OFF_BUS:    prdata[WIDTH-1:0] = bus_rdata;
				default:          prdata = 32'h00000000;
			endcase
		end
	end
endmodule // pcmx_port

// ==== pcmx_pin_dev.sv ====
// Far-side pin device: drives the port lines and the input strobe
`timescale 1ns/10ps
module pcmx_pin_dev (
	input  wire       pclk,
	input  wire [7:0] pin_out,
	input  wire [7:0] pin_oe,
	output wire [7:0] pin_in,
	output reg        input_strobe = 1'h0
);
	reg [7:0] ext_val = 8'h00;
	reg [7:0] ext_oe  = 8'h00;
	// Pull-ups: a released line reads high, never a stale value
	assign pin_in = pin_oe & pin_out | ~pin_oe & (ext_val | ~ext_oe);
	// Changes land just after a clock edge
	task put(input [7:0] v, input [7:0] oe);
		@(posedge pclk);
		ext_val <= v;
		ext_oe <= oe;
	endtask
	task strobe(input lvl);
		@(posedge pclk);
		input_strobe <= lvl;
	endtask
endmodule // pcmx_pin_dev

// ==== pcmx_port_properties.sv ====
// Assertion checker on the port C pin block boundary
`timescale 1ns/10ps
module pcmx_port_props #(
	parameter WIDTH = 8
) (
	input wire             pclk,
	input wire             presetn,
	input wire             psel,
	input wire             penable,
	input wire             pwrite,
	input wire             expanded_mode,
	input wire             port_tristate_ctl,
	input wire             addr_path_sel,
	input wire             wdata_path_sel,
	input wire             rdata_path_sel,
	input wire             internal_read,
	input wire             output_strobe,
	input wire             strobe_a_flag,
	input wire             internal_read_visible,
	input wire [WIDTH-1:0] bus_addr,
	input wire [WIDTH-1:0] bus_wdata,
	input wire [WIDTH-1:0] bus_rdata,
	input wire [WIDTH-1:0] pin_out,
	input wire [WIDTH-1:0] pin_oe
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_addr;
		expanded_mode && !port_tristate_ctl && addr_path_sel |-> &pin_oe && pin_out == bus_addr;
	endproperty
	a_addr: assert property (p_addr) else $error("bad address phase");
	property p_float;
		expanded_mode && port_tristate_ctl |-> pin_oe == '0;
	endproperty
	a_float: assert property (p_float) else $error("pins driven");
	property p_wdata;
		expanded_mode && !port_tristate_ctl && wdata_path_sel && !addr_path_sel && !internal_read
			|-> &pin_oe && pin_out == bus_wdata;
	endproperty
	a_wdata: assert property (p_wdata) else $error("bad write data");
	property p_hide;
		expanded_mode && internal_read && !internal_read_visible && !addr_path_sel |-> pin_oe == '0;
	endproperty
	a_hide: assert property (p_hide) else $error("internal read shown");
	// Read data may move only one cycle behind an open read path
	property p_rhold;
		!rdata_path_sel && !$past(rdata_path_sel) |-> $stable(bus_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data moved");
	property p_oend;
		$rose(strobe_a_flag) |-> !output_strobe;
	endproperty
	a_oend: assert property (p_oend) else $error("strobe not ended");
	property p_dir0;
		!expanded_mode && !$past(presetn) |-> pin_oe == '0;
	endproperty
	a_dir0: assert property (p_dir0) else $error("pins driven at reset");
	property p_irv;
		!(psel && penable && pwrite) |=> $stable(internal_read_visible);
	endproperty
	a_irv: assert property (p_irv) else $error("visibility moved");
endmodule // pcmx_port_props

bind pcmx_port pcmx_port_props #(.WIDTH(WIDTH)) u_props (.*);

// ==== tb.sv ====
// Self-checking bench for the port C pin block
`timescale 1ns/10ps
`include "pcmx_regs.vh"
module tb;
	reg         pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	reg         expanded_mode = '0, port_tristate_ctl = '1, addr_path_sel = '0;
	reg         wdata_path_sel = '0, rdata_path_sel = '0, internal_read = '0;
	reg         clk_en = '1, lowpower_n = '1;
	reg  [1:0]  ec = '0;
	reg  [11:0] paddr = '0;
	reg  [31:0] pwdata = '0, rv;
	reg  [7:0]  bus_addr = '0, bus_wdata = '0, internal_rdata = '0;
	wire [31:0] prdata;
	wire [7:0]  bus_rdata, pin_in, pin_out, pin_oe;
	wire        pready, pslverr, input_strobe, output_strobe, strobe_a_flag;
	wire        internal_read_visible;
	integer     n_fail = 0, checks_done = 0, k, m;
	pcmx_port dut (.*, .e_clk(ec[1]));
	pcmx_pin_dev dev (.*);
	// Bus clock at 40 MHz, E at a quarter of it
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) ec <= ec + 2'h1;
	task chk(input string nm, input [7:0] e, input [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer; a missing pready ends the run
	task xfer(input w, input [11:0] a, input [7:0] d);
		psel <= '1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk) penable <= '1;
		@(posedge pclk);
		for (k = 0; pready !== 1'h1 && k < 9; k++) @(posedge pclk);
		if (k == 9) begin
			n_fail++;
			complete_run;
		end
		rv = prdata;
		chk("pslverr", 8'h00, {7'h00, pslverr});
		psel <= '0;
		penable <= '0;
		@(posedge pclk);
	endtask
	task rd(input string nm, input [11:0] a, input [7:0] e);
		xfer('0, a, 8'h00);
		chk(nm, e, rv[7:0]);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= '1;
		@(posedge pclk);
		rd("dir", `PCMX_OFF_DIR, 8'h00);
		rd("ctrl", `PCMX_OFF_CTRL, 8'h00);
		rd("pins", `PCMX_OFF_DATA, 8'hff);
		rd("hole", 12'h020, 8'h00);
		xfer('1, `PCMX_OFF_DIR, 8'h0f);
		rd("dir", `PCMX_OFF_DIR, 8'h0f);
		// A write while the clock enable is low must leave state alone
		clk_en <= '0;
		xfer('1, `PCMX_OFF_DIR, 8'hff);
		clk_en <= '1;
		rd("frozen dir", `PCMX_OFF_DIR, 8'h0f);
		xfer('1, `PCMX_OFF_DATA, 8'ha5);
		dev.put(8'h30, 8'hf0);
		repeat (3) @(posedge pclk);
		chk("oe", 8'h0f, pin_oe);
		rd("data", `PCMX_OFF_DATA, 8'h35);
		xfer('1, `PCMX_OFF_LATCH, 8'h5a);
		chk("out", 8'h0a, pin_out & pin_oe);
		xfer('1, `PCMX_OFF_CTRL, 8'h01);
		chk("od", 8'h05, pin_oe);
		xfer('1, `PCMX_OFF_DIR, 8'h00);
		xfer('1, `PCMX_OFF_CTRL, 8'h08);
		dev.put(8'hc3, 8'hff);
		dev.strobe('1);
		for (k = 0; strobe_a_flag !== 1'h1 && k < 12; k++) @(posedge pclk);
		chk("flag", 8'h01, strobe_a_flag);
		rd("latch", `PCMX_OFF_LATCH, 8'hc3);
		// Status read arms the auto-clear, the next latch read clears the flag
		rd("status", `PCMX_OFF_STATUS, 8'h01);
		rd("latch", `PCMX_OFF_LATCH, 8'hc3);
		chk("flag clr", 8'h00, strobe_a_flag);
		// Low power: input buffers off, strobe edges latch nothing
		lowpower_n <= '0;
		dev.put(8'h5a, 8'hff);
		rd("asleep", `PCMX_OFF_DATA, 8'h00);
		dev.strobe('0);
		dev.strobe('1);
		repeat (4) @(posedge pclk);
		rd("sleep latch", `PCMX_OFF_LATCH, 8'hc3);
		chk("sleep flag", 8'h00, strobe_a_flag);
		lowpower_n <= '1;
		$display("test port done");
		// Simple, full-input and full-output handshake in turn
		dev.put(8'h00, 8'h00);
		for (m = 0; m < 3; m++) begin
			dev.strobe('0);
			xfer('1, `PCMX_OFF_CTRL, m == 0 ? 8'h08 : m == 1 ? 8'h0a : 8'h0e);
			xfer(m != 1, m == 0 ? `PCMX_OFF_DATA : `PCMX_OFF_LATCH, 8'h3c);
			if (m == 2) chk("oe idle", 8'h00, pin_oe);
			chk("strobe out", 8'h01, output_strobe);
			dev.strobe('1);
			for (k = 0; output_strobe !== 1'h0 && k < `PCMX_E_CYCLES; k++) @(posedge pclk);
			chk("strobe end", 8'h00, output_strobe);
			if (m == 2) chk("oe active", 8'hff, pin_oe);
		end
		$display("test handshake done");
		xfer('1, `PCMX_OFF_CTRL, 8'h00);
		expanded_mode <= '1;
		port_tristate_ctl <= '0;
		addr_path_sel <= '1;
		bus_addr <= 8'h12;
		bus_wdata <= 8'h34;
		@(posedge pclk);
		chk("addr", 8'h12, pin_out);
		addr_path_sel <= '0;
		wdata_path_sel <= '1;
		@(posedge pclk);
		chk("wdata", 8'h34, pin_out);
		wdata_path_sel <= '0;
		port_tristate_ctl <= '1;
		rdata_path_sel <= '1;
		dev.put(8'h9c, 8'hff);
		for (k = 0; bus_rdata !== 8'h9c && k < 12; k++) @(posedge pclk);
		chk("rdata", 8'h9c, bus_rdata);
		// Internal read: hidden until visibility is set, then driven out
		rdata_path_sel <= '0;
		port_tristate_ctl <= '0;
		internal_read <= '1;
		internal_rdata <= 8'h66;
		@(posedge pclk);
		chk("irv hide", 8'h00, pin_oe);
		xfer('1, `PCMX_OFF_CTRL, 8'h10);
		chk("irv", 8'h01, internal_read_visible);
		chk("irv show", 8'h66, pin_out & pin_oe);
		// Mid-run reset clears the direction register
		internal_read <= '0;
		expanded_mode <= '0;
		xfer('1, `PCMX_OFF_DIR, 8'hff);
		chk("oe all", 8'hff, pin_oe);
		presetn <= '0;
		@(posedge pclk);
		chk("reset oe", 8'h00, pin_oe);
		presetn <= '1;
		@(posedge pclk);
		rd("reset dir", `PCMX_OFF_DIR, 8'h00);
		$display("test bus done");
		complete_run;
	end
endmodule // tb
